// ===== cwrc_ctrl.sv
// Purpose: Recovery watchdog, reset pulse and control bytes of a clock chip
// Assumes: Byte requests arrive from a serial engine on link_clock
// Notes: Requests cross to the core clock by a toggle handshake
`timescale 1ns/10ps
module cwrc_ctrl
  import cwrc_pkg::*;
#(
  parameter longint FAST_CYC = CWRC_FAST_CYC,
  parameter longint SLOW_CYC = CWRC_SLOW_CYC,
  parameter int PULSE_CYC = CWRC_PULSE_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  input wire logic link_clock,
  input wire logic link_req,
  input wire cwrc_req_s link_cmd,
  output logic link_ready,
  output logic link_done,
  output logic [7:0] link_rdata,
  input wire logic [4:0] strap_select_inputs,
  input wire logic [4:0] sw_select,
  input wire logic [4:0] timer_load_value,
  input wire logic timer_scale_sel,
  input wire logic freq_change_evt,
  input wire logic [7:0] prog_freq_mhz,
  output logic memory_clock_strength_sel,
  output logic bus_clock_strength_sel,
  output logic freq_source_override,
  output logic [4:0] ratio_select,
  output logic recovery_mode,
  output logic recovery_use_nm,
  output logic [7:0] recovery_n_value,
  output logic [6:0] recovery_m_value,
  output logic freq_apply,
  output logic freq_writes_locked,
  output logic prog_freq_ok,
  output logic signed [3:0] cpu_skew_steps,
  output logic signed [3:0] mem_skew_steps,
  output logic signed [2:0] graphics_clock_delay,
  output logic system_reset
);
  localparam logic [26:0] FAST_LAST = 27'(FAST_CYC - 1);
  localparam logic [26:0] SLOW_LAST = 27'(SLOW_CYC - 1);
  localparam logic [7:0] PULSE_LOAD = 8'(PULSE_CYC);

  // Link domain state
  logic l_busy_r, l_req_tgl_r, l_ack_s1_r, l_ack_s2_r, l_ack_seen_r;
  logic l_done_r;
  logic [7:0] l_rdata_r;
  cwrc_req_s l_cmd_r;
  // Core domain state
  logic c_req_s1_r, c_req_s2_r, c_req_seen_r, c_ack_tgl_r;
  logic [7:0] c_rdata_r;
  logic [4:0] strap_s1_r, strap_s2_r, strap_prev_r, strap_latch_r;
  logic strap_taken_r;
  logic [1:0] strap_fill_r;
  logic [7:0] ctrl_r, skew_r, rec_n_r;
  logic [6:0] rec_m_r;
  logic rec_sel_r, to_flag_r, apply_r;
  cwrc_wd_e wd_r;
  logic [26:0] tick_r;
  logic [4:0] wd_cnt_r;
  logic [7:0] pulse_r;

  // Link side: capture a request, toggle, wait for returned toggle
  wire l_take = link_req && !l_busy_r;
  wire l_ack_edge = l_ack_s2_r ^ l_ack_seen_r;
  assign link_ready = !l_busy_r;
  assign link_done = l_done_r;
  assign link_rdata = l_rdata_r;

  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      l_busy_r <= 1'b0;
      l_req_tgl_r <= 1'b0;
      l_cmd_r <= '0;
      l_ack_s1_r <= 1'b0;
      l_ack_s2_r <= 1'b0;
      l_ack_seen_r <= 1'b0;
      l_done_r <= 1'b0;
      l_rdata_r <= 8'h00;
    end else begin
      l_ack_s1_r <= c_ack_tgl_r;
      l_ack_s2_r <= l_ack_s1_r;
      l_ack_seen_r <= l_ack_s2_r;
      l_done_r <= l_ack_edge;
      if (l_take) begin
        l_cmd_r <= link_cmd;
        l_req_tgl_r <= ~l_req_tgl_r;
        l_busy_r <= 1'b1;
      end else if (l_ack_edge) begin
        l_busy_r <= 1'b0;
        l_rdata_r <= c_rdata_r;
      end
    end
  end

  // Core side request decode
  wire c_req = (c_req_s2_r ^ c_req_seen_r) && clock_en;
  wire c_wr = c_req && l_cmd_r.write;
  wire wr_ctrl = c_wr && (l_cmd_r.addr == CWRC_OFS_RST_WD);
  wire wr_skew = c_wr && (l_cmd_r.addr == CWRC_OFS_SKEW);
  wire in_rec = (wd_r == CWRC_RECOVER);
  wire wr_n = c_wr && (l_cmd_r.addr == CWRC_OFS_REC_N) && !in_rec;
  wire wr_m = c_wr && (l_cmd_r.addr == CWRC_OFS_REC_M) && !in_rec;
  wire [7:0] wd8 = l_cmd_r.wdata;
  wire en_clear = wr_ctrl && !wd8[CWRC_B_TMR_EN];
  // Override bit frozen in recovery so the frequency cannot move
  wire ovr_nxt = in_rec ? ctrl_r[CWRC_B_OVERRIDE] : wd8[CWRC_B_OVERRIDE];
  wire [7:0] ctrl_nxt = {wd8[7:6], ovr_nxt, wd8[4:3], 1'b0, wd8[1], 1'b0};

  // Watchdog tick and time-out decode
  wire [26:0] tick_last = timer_scale_sel ? SLOW_LAST : FAST_LAST;
  wire tick = (tick_r == tick_last);
  wire armed = (wd_r == CWRC_ARMED);
  wire timeout = clock_en && armed && tick && (wd_cnt_r <= 5'h01);
  wire fc_evt = freq_change_evt || apply_r;
  wire fire_to = timeout && ctrl_r[CWRC_B_RST_TO];
  wire fire_fc = clock_en && fc_evt && ctrl_r[CWRC_B_RST_FC];
  wire flag_clr = wr_ctrl && wd8[CWRC_B_TO_FLAG];

  // Read data; reserved bit 0 and unmapped bytes read zero
  wire [7:0] ctrl_rd = {ctrl_r[7:3], to_flag_r, ctrl_r[1], 1'b0};
  wire [7:0] rd_mux =
    (l_cmd_r.addr == CWRC_OFS_RST_WD) ? ctrl_rd :
    (l_cmd_r.addr == CWRC_OFS_SKEW) ? skew_r :
    (l_cmd_r.addr == CWRC_OFS_REC_N) ? rec_n_r :
    (l_cmd_r.addr == CWRC_OFS_REC_M) ? {rec_sel_r, rec_m_r} : 8'h00;

  // Handshake synchroniser, read capture and acknowledge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      c_req_s1_r <= 1'b0;
      c_req_s2_r <= 1'b0;
      c_req_seen_r <= 1'b0;
      c_ack_tgl_r <= 1'b0;
      c_rdata_r <= 8'h00;
    end else if (clock_en) begin
      c_req_s1_r <= l_req_tgl_r;
      c_req_s2_r <= c_req_s1_r;
      c_req_seen_r <= c_req_s2_r;
      if (c_req) begin
        c_rdata_r <= rd_mux;
        c_ack_tgl_r <= ~c_ack_tgl_r;
      end
    end
  end

  // Strap pins synchronised, then latched once they hold for two cycles
  wire strap_steady = (strap_fill_r == CWRC_STRAP_FILL) &&
                      (strap_s2_r == strap_prev_r);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strap_s1_r <= 5'h00;
      strap_s2_r <= 5'h00;
      strap_prev_r <= 5'h00;
      strap_latch_r <= 5'h00;
      strap_taken_r <= 1'b0;
      strap_fill_r <= 2'h0;
    end else if (clock_en) begin
      strap_s1_r <= strap_select_inputs;
      strap_s2_r <= strap_s1_r;
      strap_prev_r <= strap_s2_r;
      if (strap_fill_r != CWRC_STRAP_FILL) begin
        strap_fill_r <= strap_fill_r + 2'h1;
      end
      if (!strap_taken_r && strap_steady) begin
        strap_latch_r <= strap_s2_r;
        strap_taken_r <= 1'b1;
      end
    end
  end

  // Control bytes; N or M writes schedule a frequency apply
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= CWRC_RST_CTRL;
      skew_r <= CWRC_RST_SKEW;
      rec_n_r <= CWRC_RST_N;
      rec_m_r <= CWRC_RST_M;
      rec_sel_r <= 1'b0;
      apply_r <= 1'b0;
    end else if (clock_en) begin
      if (wr_ctrl) ctrl_r <= ctrl_nxt;
      if (wr_skew) skew_r <= wd8;
      if (wr_n) rec_n_r <= wd8;
      if (wr_m) begin
        rec_m_r <= wd8[6:0];
        rec_sel_r <= wd8[CWRC_B_REC_SEL];
      end
      apply_r <= wr_n || wr_m;
    end
  end

  // Time-out flag: a new time-out wins over a clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      to_flag_r <= 1'b0;
    end else if (timeout) begin
      to_flag_r <= 1'b1;
    end else if (flag_clr) begin
      to_flag_r <= 1'b0;
    end
  end

  // Watchdog state, prescaler and down counter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wd_r <= CWRC_IDLE;
      tick_r <= 27'h0000000;
      wd_cnt_r <= 5'h00;
    end else if (clock_en) begin
      if (en_clear || !ctrl_r[CWRC_B_TMR_EN]) begin
        wd_r <= CWRC_IDLE;
        tick_r <= 27'h0000000;
        wd_cnt_r <= timer_load_value;
      end else begin
        unique case (wd_r)
          CWRC_IDLE: begin
            if (fc_evt) begin
              wd_r <= CWRC_ARMED;
              tick_r <= 27'h0000000;
              wd_cnt_r <= timer_load_value;
            end
          end
          CWRC_ARMED: begin
            tick_r <= tick ? 27'h0000000 : tick_r + 27'h0000001;
            if (timeout) wd_r <= CWRC_RECOVER;
            else if (tick) wd_cnt_r <= wd_cnt_r - 5'h01;
          end
          CWRC_RECOVER: wd_r <= CWRC_RECOVER;
        endcase
      end
    end
  end

  // Reset pulse of fixed width, retriggered by each time-out or change event whose reset bit is set
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pulse_r <= 8'h00;
    end else if (clock_en) begin
      if (fire_to || fire_fc) pulse_r <= PULSE_LOAD;
      else if (pulse_r != 8'h00) pulse_r <= pulse_r - 8'h01;
    end
  end

  // Outputs decoded from the control bytes
  assign memory_clock_strength_sel = ctrl_r[CWRC_B_MEM_DRV];
  assign bus_clock_strength_sel = ctrl_r[CWRC_B_BUS_DRV];
  assign freq_source_override = ctrl_r[CWRC_B_OVERRIDE];
  // Ratio source, also used for recovery ratios
  assign ratio_select = freq_source_override ? sw_select : strap_latch_r;
  assign recovery_mode = in_rec;
  assign freq_writes_locked = in_rec;
  assign recovery_use_nm = in_rec && rec_sel_r;
  assign recovery_n_value = rec_n_r;
  assign recovery_m_value = rec_m_r;
  assign freq_apply = apply_r;
  assign prog_freq_ok = (prog_freq_mhz >= CWRC_FMIN_MHZ) &&
                        (prog_freq_mhz <= CWRC_FMAX_MHZ);
  assign system_reset = (pulse_r != 8'h00);
  // Skew codes as signed counts of 150 ps steps
  wire [2:0] cpu_code = skew_r[7:5];
  wire [2:0] mem_code = skew_r[4:2];
  assign cpu_skew_steps = cpu_code[2] ? $signed({1'b0, cpu_code} - 4'h3)
                                      : -$signed({1'b0, cpu_code});
  assign mem_skew_steps = mem_code[2] ? $signed({1'b0, mem_code} - 4'h3)
                                      : -$signed({1'b0, mem_code});
  wire [1:0] gfx_code = skew_r[1:0];
  assign graphics_clock_delay = (gfx_code == 2'b01) ? -3'sd1 :
                                (gfx_code == 2'b10) ? 3'sd1 :
                                (gfx_code == 2'b11) ? 3'sd2 : 3'sd0;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  mem_drive_a: assert property (memory_clock_strength_sel ==
    ctrl_r[7]) else $error("memory drive not bit 7");
  bus_drive_a: assert property (bus_clock_strength_sel ==
    ctrl_r[6]) else $error("bus drive not bit 6");
  ratio_src_a: assert property (!freq_source_override |->
    ratio_select == strap_latch_r) else $error("strap not used");
  to_reset_a: assert property (timeout && ctrl_r[4] |=>
    system_reset [*8]) else $error("no time-out reset");
  no_reset_a: assert property (clock_en && !fc_evt && !timeout &&
    pulse_r == 8'h00 |=> !system_reset) else $error("stray reset");
  fc_reset_a: assert property (fire_fc |=> system_reset)
    else $error("no change reset");
  flag_set_a: assert property (timeout |=> to_flag_r)
    else $error("flag not set");
  flag_clr_a: assert property (flag_clr && !timeout |=> !to_flag_r)
    else $error("flag not cleared");
  unlock_a: assert property (en_clear |=> !recovery_mode)
    else $error("recovery not released");
  lock_a: assert property (timeout && !en_clear |=> recovery_mode)
    else $error("recovery not locked");
  wr_lock_a: assert property (in_rec |=> $stable({rec_n_r, rec_m_r}))
    else $error("recovery value changed");
  skew_map_a: assert property (skew_r[7:5] == 3'b111 |->
    cpu_skew_steps == 4'sd4) else $error("skew +600 wrong");
  apply_nm_a: assert property (wr_n |=> freq_apply)
    else $error("no apply on N write");
endmodule

// ===== cwrc_pkg.sv
// Purpose: Shared constants and types of the clock watchdog recovery control
// Assumes: 40 MHz core clock, byte-wide control registers
// Notes: Cycle counts are derived from the printed times
package cwrc_pkg;
  // Register byte addresses
  localparam logic [7:0] CWRC_OFS_RST_WD = 8'h09;
  localparam logic [7:0] CWRC_OFS_SKEW = 8'h0A;
  localparam logic [7:0] CWRC_OFS_REC_N = 8'h0B;
  localparam logic [7:0] CWRC_OFS_REC_M = 8'h0C;
  // Field positions in the reset and watchdog control byte, and of the select bit in the M byte
  localparam int CWRC_B_MEM_DRV = 7;
  localparam int CWRC_B_BUS_DRV = 6;
  localparam int CWRC_B_OVERRIDE = 5;
  localparam int CWRC_B_RST_TO = 4;
  localparam int CWRC_B_RST_FC = 3;
  localparam int CWRC_B_TO_FLAG = 2;
  localparam int CWRC_B_TMR_EN = 1;
  localparam int CWRC_B_REC_SEL = 7;
  // Values after reset
  localparam logic [7:0] CWRC_RST_CTRL = 8'h00;
  localparam logic [7:0] CWRC_RST_SKEW = 8'h00;
  localparam logic [7:0] CWRC_RST_N = 8'h00;
  localparam logic [6:0] CWRC_RST_M = 7'h00;
  // Timing
  localparam longint CWRC_CLOCK_HZ = 40_000_000;
  localparam longint CWRC_FAST_MS = 150;
  localparam longint CWRC_SLOW_MS = 2500;
  localparam longint CWRC_FAST_CYC = CWRC_CLOCK_HZ / 1000 * CWRC_FAST_MS;
  localparam longint CWRC_SLOW_CYC = CWRC_CLOCK_HZ / 1000 * CWRC_SLOW_MS;
  localparam int CWRC_PULSE_CYC = 64;
  // Core cycles before the strap pipeline holds real pin samples
  localparam logic [1:0] CWRC_STRAP_FILL = 2'h3;
  // Supported programmable CPU frequency range
  localparam logic [7:0] CWRC_FMIN_MHZ = 8'h32;
  localparam logic [7:0] CWRC_FMAX_MHZ = 8'hF8;

  typedef enum logic [1:0] {CWRC_IDLE, CWRC_ARMED, CWRC_RECOVER} cwrc_wd_e;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cwrc_req_s;
endpackage

// ===== cwrc_host.sv
// Purpose: Host model issuing byte requests on the link side
// Assumes: One request at a time, link_clock runs from the bench
// Notes: Released command lines show the inverse of the last value
`timescale 1ns/10ps
module cwrc_host
  import cwrc_pkg::*;
(
  input wire logic link_clock,
  input wire logic link_ready,
  input wire logic link_done,
  input wire logic [7:0] link_rdata,
  output logic link_req,
  output cwrc_req_s link_cmd
);
  // Transfers that never saw ready or done
  int hangs = 0;
  // Idle lines at time zero
  initial begin
    link_req = 1'b0;
    link_cmd = '0;
  end
  // One whole byte transfer; request, then wait for done
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
    int n;
    @(posedge link_clock);
    link_req <= 1'b1;
    link_cmd <= '{write: wr, addr: a, wdata: d};
    n = 0;
    do @(posedge link_clock); while (link_ready !== 1'b1 && n++ < 50);
    if (n > 50) hangs++;
    link_req <= 1'b0;
    link_cmd <= ~link_cmd;
    n = 0;
    do @(posedge link_clock); while (link_done !== 1'b1 && n++ < 50);
    if (n > 50) hangs++;
    rd = link_rdata;
  endtask
endmodule

// ===== test_cwrc_ctrl.sv
// Purpose: Self-checking bench of the clock watchdog recovery control
// Assumes: Short prescale and pulse counts set by parameter
// Notes: Core inputs change on falling clock edges
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  $display("wrong value %s exp %h got %h", n, e, s); fails++; end end
module test_cwrc_ctrl
  import cwrc_pkg::*;
;
  localparam int PULSE = 8;
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic reset_n = 1'b0;
  logic link_req, link_ready, link_done;
  cwrc_req_s link_cmd;
  logic [7:0] link_rdata, rn, prog_freq_mhz = 8'h00;
  logic [4:0] sw_select = 5'h0A, strap = 5'h15, load = 5'h02;
  logic evt = 1'b0, scale = 1'b0;
  logic mem_drv, bus_drv, ovr, rec_mode, use_nm, apply, locked, f_ok, sys_rst;
  logic [4:0] ratio;
  logic [6:0] rm;
  logic signed [3:0] cpu_sk, mem_sk;
  logic signed [2:0] gfx_sk;
  int fails = 0, compares = 0, cycles = 0, rst_cnt = 0, apply_cnt = 0;
  always #12.5 clock = ~clock;
  initial #7 forever #16 link_clock = ~link_clock;
  cwrc_ctrl #(.FAST_CYC(20), .SLOW_CYC(50), .PULSE_CYC(PULSE)) DUT (
    .clock(clock), .reset_n(reset_n), .clock_en(1'b1),
    .link_clock(link_clock), .link_req(link_req), .link_cmd(link_cmd),
    .link_ready(link_ready), .link_done(link_done), .link_rdata(link_rdata),
    .strap_select_inputs(strap), .sw_select(sw_select),
    .timer_load_value(load), .timer_scale_sel(scale), .freq_change_evt(evt),
    .prog_freq_mhz(prog_freq_mhz), .memory_clock_strength_sel(mem_drv),
    .bus_clock_strength_sel(bus_drv), .freq_source_override(ovr),
    .ratio_select(ratio), .recovery_mode(rec_mode), .recovery_use_nm(use_nm),
    .recovery_n_value(rn), .recovery_m_value(rm), .freq_apply(apply),
    .freq_writes_locked(locked), .prog_freq_ok(f_ok),
    .cpu_skew_steps(cpu_sk), .mem_skew_steps(mem_sk),
    .graphics_clock_delay(gfx_sk), .system_reset(sys_rst));
  cwrc_host host (.link_clock(link_clock), .link_ready(link_ready),
    .link_done(link_done), .link_rdata(link_rdata), .link_req(link_req),
    .link_cmd(link_cmd));
  // Pulse counters and hang limit
  always @(posedge clock) begin
    cycles++;
    rst_cnt += (sys_rst === 1'b1);
    apply_cnt += (apply === 1'b1);
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    fails += host.hangs;
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    host.xfer(1'b0, a, 8'h00, x);
    `CHK("rdata", e, x)
  endtask
  task automatic pulse_evt();
    @(negedge clock) evt = 1'b1;
    @(negedge clock) evt = 1'b0;
  endtask
  // Values after reset and an unmapped byte
  task automatic t_reset();
    rd(CWRC_OFS_RST_WD, 8'h00);
    rd(CWRC_OFS_SKEW, 8'h00);
    rd(CWRC_OFS_REC_N, 8'h00);
    rd(CWRC_OFS_REC_M, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
  endtask
  // Drive strength, reserved bit and frequency source
  task automatic t_ctrl();
    wr(CWRC_OFS_RST_WD, 8'hC1);
    rd(CWRC_OFS_RST_WD, 8'hC0);
    `CHK("mem_drv", 1'b1, mem_drv)
    `CHK("bus_drv", 1'b1, bus_drv)
    `CHK("ratio", 5'h15, ratio)
    `CHK("ovr", 1'b0, ovr)
    wr(CWRC_OFS_RST_WD, 8'h20);
    `CHK("ovr", 1'b1, ovr)
    `CHK("mem_drv", 1'b0, mem_drv)
    `CHK("bus_drv", 1'b0, bus_drv)
    `CHK("ratio", 5'h0A, ratio)
    wr(CWRC_OFS_RST_WD, 8'h00);
  endtask
  // Every skew code of both field widths
  task automatic t_skew();
    logic signed [3:0] e;
    logic signed [2:0] g [4] = '{3'sd0, -3'sd1, 3'sd1, 3'sd2};
    for (int c = 0; c < 8; c++) begin
      wr(CWRC_OFS_SKEW, {c[2:0], c[2:0], c[1:0]});
      e = (c == 0) ? 4'sd0 : (c < 4) ? -4'(c) : 4'(c - 3);
      `CHK("cpu_skew", e, cpu_sk)
      `CHK("mem_skew", e, mem_sk)
      `CHK("gfx_skew", g[c[1:0]], gfx_sk)
    end
  endtask
  // Frequency apply and change reset pulses
  task automatic t_apply();
    wr(CWRC_OFS_RST_WD, 8'h08);
    {rst_cnt, apply_cnt} = '0;
    wr(CWRC_OFS_REC_N, 8'h33);
    repeat (20) @(negedge clock);
    `CHK("apply", 1, apply_cnt)
    `CHK("fc_reset", PULSE, rst_cnt)
    wr(CWRC_OFS_RST_WD, 8'h00);
    {rst_cnt, apply_cnt} = '0;
    wr(CWRC_OFS_REC_M, 8'h85);
    pulse_evt();
    repeat (20) @(negedge clock);
    `CHK("apply", 1, apply_cnt)
    `CHK("fc_reset", 0, rst_cnt)
    `CHK("n_value", 8'h33, rn)
    `CHK("m_value", 7'h05, rm)
  endtask
  // Time-out, locked recovery, flag clear and unlock
  task automatic t_timeout();
    int n;
    wr(CWRC_OFS_RST_WD, 8'h12);
    rst_cnt = 0;
    pulse_evt();
    n = 0;
    while (rec_mode !== 1'b1 && n++ < 300) @(negedge clock);
    repeat (20) @(negedge clock);
    `CHK("to_reset", PULSE, rst_cnt)
    `CHK("use_nm", 1'b1, use_nm)
    rd(CWRC_OFS_RST_WD, 8'h16);
    wr(CWRC_OFS_REC_N, 8'h44);
    rd(CWRC_OFS_REC_N, 8'h33);
    `CHK("locked", 1'b1, locked)
    wr(CWRC_OFS_RST_WD, 8'h36);
    rd(CWRC_OFS_RST_WD, 8'h12);
    `CHK("ovr", 1'b0, ovr)
    `CHK("rec_mode", 1'b1, rec_mode)
    wr(CWRC_OFS_RST_WD, 8'h10);
    `CHK("rec_mode", 1'b0, rec_mode)
    pulse_evt();
    repeat (150) @(negedge clock);
    `CHK("rec_mode", 1'b0, rec_mode)
    `CHK("ratio", 5'h15, ratio)
  endtask
  // Slow prescale: time-out after two slow ticks, not before
  task automatic t_scale();
    @(negedge clock) scale = 1'b1;
    wr(CWRC_OFS_RST_WD, 8'h02);
    pulse_evt();
    repeat (60) @(negedge clock);
    `CHK("rec_early", 1'b0, rec_mode)
    repeat (45) @(negedge clock);
    `CHK("rec_slow", 1'b1, rec_mode)
    rd(CWRC_OFS_RST_WD, 8'h06);
    wr(CWRC_OFS_RST_WD, 8'h04);
    rd(CWRC_OFS_RST_WD, 8'h00);
    @(negedge clock) scale = 1'b0;
  endtask
  // Programmed frequency range edges
  task automatic t_range();
    logic [7:0] f [4] = '{8'd49, 8'd50, 8'd248, 8'd249};
    logic ok [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      @(negedge clock) prog_freq_mhz = f[i];
      @(negedge clock);
      `CHK("freq_ok", ok[i], f_ok)
    end
  endtask
  initial begin
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_ctrl();
    t_skew();
    t_apply();
    t_timeout();
    t_scale();
    t_range();
    complete_run();
  end
endmodule
